/* File: logic/pof_pkg.sv */
/*
 * pof_pkg: constants, field layouts and carrier types for the pixel output block.
 * Assumes: shared by pof_top, pof_sink_model and the testbench; pof_buf does not depend on it.
 */
`default_nettype none
package pof_pkg;
    localparam int COLOR_W = 10;
    localparam int COLOR_MSB = 9;
    localparam int SUB_W = 3;
    localparam int PHASE_W = 2;
    localparam int DUR_W = 8;
    localparam int LINE_W = 12;
    localparam int FILT_W = 3;
    localparam int STEADY_W = 3;
    // link cycles an hsync level must hold before the filtered copy follows
    localparam logic [FILT_W-1:0] FILT_CYC = 3'h4;
    // sub-slot of the pixel period in which the sample is taken
    localparam logic [1:0] SAMPLE_SLOT = 2'h0;
    // sub-slot in which the output registers load the next word
    localparam logic [1:0] DATA_SLOT = 2'h2;
    localparam logic [1:0] QUARTER_SHIFT = 2'h1;
    localparam logic [STEADY_W-1:0] STEADY_MAX = 3'h7;

    typedef enum logic [1:0] {
        POF_SLICE_GREEN_RAW,
        POF_SLICE_HSYNC_RAW,
        POF_SLICE_REGEN,
        POF_SLICE_FILT
    } pof_slice_e;

    typedef enum logic [1:0] {
        POF_STB_PIXEL,
        POF_STB_QUARTER,
        POF_STB_DOUBLE,
        POF_STB_HALF
    } pof_stb_e;

    typedef struct packed {
        pof_slice_e slice_sel;
        pof_stb_e strobe_sel;
        logic clk_src_ext;
        logic [PHASE_W-1:0] phase;
        logic line_pol;
        logic [DUR_W-1:0] line_dur;
    } pof_cfg_s;

    localparam pof_cfg_s CFG_RST = '{
        slice_sel: POF_SLICE_GREEN_RAW,
        strobe_sel: POF_STB_PIXEL,
        clk_src_ext: 1'b0,
        phase: 2'h0,
        line_pol: 1'b0,
        line_dur: 8'h20
    };

    typedef struct packed {
        logic [COLOR_W-1:0] red;
        logic [COLOR_W-1:0] green;
        logic [COLOR_W-1:0] blue;
    } pof_rgb_s;

    typedef struct packed {
        pof_rgb_s rgb;
        logic hsync;
    } pof_pix_s;

    localparam int PIX_W = $bits(pof_pix_s);
endpackage
`default_nettype wire

/* File: logic/pof_buf.sv */
/*
 * pof_buf: two-entry buffer with valid/ready on both sides, head word registered.
 * Assumes: single clock; producer and consumer follow valid/ready rules.
 */
`default_nettype none
module pof_buf #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic [W-1:0] e0_q;
    logic [W-1:0] e0_d;
    logic [W-1:0] e1_q;
    logic [W-1:0] e1_d;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = e0_q;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb
    begin
        cnt_d = cnt_q;
        e0_d = e0_q;
        e1_d = e1_q;
        if (push && !pop)
        begin
            cnt_d = cnt_q + 2'h1;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - 2'h1;
        end
        if (pop)
        begin
            e0_d = (cnt_q == 2'h2) ? e1_q : in_data;
            if (cnt_q == 2'h2 && push)
            begin
                e1_d = in_data;
            end
        end
        else if (push)
        begin
            if (cnt_q == 2'h0)
            begin
                e0_d = in_data;
            end
            else
            begin
                e1_d = in_data;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q <= 2'h0;
            e0_q <= '0;
            e1_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
            e0_q <= e0_d;
            e1_q <= e1_d;
        end
    end
endmodule
`default_nettype wire

/* File: logic/pof_top.sv */
/*
 * pof_top: pixel output side - colour buses, selectable strobe clock, regenerated
 * line sync, field parity and the sync slicer output mux.
 * Assumes: link_clk runs at four times the pixel rate; adc words are on link_clk;
 * sync pins and the external pixel clock are asynchronous; cfg comes on clk.
 */
// Function
// - slicer pin muxes four sync sources
// - slicer output passes raw sources unprocessed
// - field parity output marks odd/even
// - colour buses carry MSB on bit 9
// - sample-to-output delay fixed while out_ready held high
// - phase setting sets sampling instant
// - data, strobe, line sync shift together
// - two-bit field selects strobe clock
// - pixel, quarter-shift, double strobe synchronous
// - fourth strobe is half pixel rate
// - pixel clock from PLL or external
// - line sync regenerated, aligned, programmable
`default_nettype none
module pof_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire pof_pkg::pof_cfg_s cfg,
    input wire logic cfg_valid,
    output logic cfg_busy,
    input wire logic link_clk,
    input wire logic external_pixel_clock_in,
    input wire logic green_sync_input,
    input wire logic horizontal_sync_input,
    input wire logic vertical_sync_input,
    input wire logic adc_valid,
    output logic adc_ready,
    input wire pof_pkg::pof_rgb_s adc_pix,
    input wire logic out_ready,
    output logic [pof_pkg::COLOR_W-1:0] red_out,
    output logic [pof_pkg::COLOR_W-1:0] green_out,
    output logic [pof_pkg::COLOR_W-1:0] blue_out,
    output logic output_strobe_clock,
    output logic line_sync_out,
    output logic field_parity_out,
    output logic sync_slicer_out
);
    // ---- clk domain: configuration hold and toggle request
    pof_pkg::pof_cfg_s hold_q;
    pof_pkg::pof_cfg_s hold_d;
    logic req_q;
    logic req_d;
    logic [1:0] ack_s_q;
    logic ack_l_q;

    assign cfg_busy = (req_q != ack_s_q[1]);

    always_comb
    begin
        hold_d = hold_q;
        req_d = req_q;
        if (cfg_valid && !cfg_busy)
        begin
            hold_d = cfg;
            req_d = ~req_q;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hold_q <= pof_pkg::CFG_RST;
            req_q <= 1'b0;
            ack_s_q <= 2'h0;
        end
        else
        begin
            hold_q <= hold_d;
            req_q <= req_d;
            ack_s_q <= {ack_s_q[0], ack_l_q};
        end
    end

    // ---- link domain: synchronisers {req, ext, vs, hs, green}
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    logic [4:0] s3_q;
    logic green_s;
    logic hs_s;
    logic vs_s;
    logic ext_s;
    logic req_s;
    logic vs_rise;
    logic ext_rise;

    always_ff @(posedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_q <= 5'h00;
            s2_q <= 5'h00;
            s3_q <= 5'h00;
        end
        else
        begin
            s1_q <= {req_q, external_pixel_clock_in, vertical_sync_input,
                     horizontal_sync_input, green_sync_input};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign green_s = s2_q[0];
    assign hs_s = s2_q[1];
    assign vs_s = s2_q[2];
    assign ext_s = s2_q[3];
    assign req_s = s2_q[4];
    assign vs_rise = vs_s & ~s3_q[2];
    assign ext_rise = ext_s & ~s3_q[3];

    // ---- link domain: config capture, sub-slot counter, hsync filter
    pof_pkg::pof_cfg_s cfg_l_q;
    pof_pkg::pof_cfg_s cfg_l_d;
    logic ack_l_d;
    logic cfg_upd;
    logic [pof_pkg::SUB_W-1:0] sc_q;
    logic [pof_pkg::SUB_W-1:0] sc_d;
    logic [pof_pkg::SUB_W-1:0] rel;
    logic [pof_pkg::SUB_W-1:0] relq;
    logic resync;
    logic [pof_pkg::FILT_W-1:0] filt_cnt_q;
    logic [pof_pkg::FILT_W-1:0] filt_cnt_d;
    logic filt_q;
    logic filt_d;
    logic [pof_pkg::STEADY_W-1:0] steady_q;
    logic [pof_pkg::STEADY_W-1:0] steady_d;

    assign cfg_upd = (req_s != ack_l_q);
    // external clock edge realigns the pixel period
    assign resync = cfg_l_q.clk_src_ext & ext_rise;
    // sampling instant offset by the phase setting
    assign rel = sc_q - {1'b0, cfg_l_q.phase};
    assign relq = rel - {1'b0, pof_pkg::QUARTER_SHIFT};

    always_comb
    begin
        cfg_l_d = cfg_upd ? hold_q : cfg_l_q;
        ack_l_d = req_s;
        sc_d = sc_q + 3'h1;
        // pixel phase follows the external clock when selected
        if (resync)
        begin
            sc_d = {sc_q[2], 2'h0};
        end
        filt_cnt_d = 3'h0;
        filt_d = filt_q;
        if (hs_s != filt_q)
        begin
            filt_cnt_d = filt_cnt_q + 3'h1;
            if (filt_cnt_q == pof_pkg::FILT_CYC - 3'h1)
            begin
                filt_d = hs_s;
                filt_cnt_d = 3'h0;
            end
        end
        steady_d = (steady_q == pof_pkg::STEADY_MAX) ? steady_q : steady_q + 3'h1;
        if (cfg_upd || resync)
        begin
            steady_d = 3'h0;
        end
    end

    always_ff @(posedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_l_q <= pof_pkg::CFG_RST;
            ack_l_q <= 1'b0;
            sc_q <= 3'h0;
            filt_cnt_q <= 3'h0;
            filt_q <= 1'b0;
            steady_q <= 3'h0;
        end
        else
        begin
            cfg_l_q <= cfg_l_d;
            ack_l_q <= ack_l_d;
            sc_q <= sc_d;
            filt_cnt_q <= filt_cnt_d;
            filt_q <= filt_d;
            steady_q <= steady_d;
        end
    end

    // ---- sample capture and buffer
    pof_pkg::pof_pix_s take_pix;
    pof_pkg::pof_pix_s buf_pix;
    logic buf_in_ready;
    logic buf_valid;
    logic out_load;

    // sample enters the buffer at its slot; path length fixed while out_ready high
    assign adc_ready = (rel[1:0] == pof_pkg::SAMPLE_SLOT) & buf_in_ready;
    assign take_pix = '{rgb: adc_pix, hsync: hs_s};
    // load slot tracks the phase too
    assign out_load = (rel[1:0] == pof_pkg::DATA_SLOT) & out_ready & buf_valid;

    pof_buf #(
        .W(pof_pkg::PIX_W)
    ) u_buf (
        .clk(link_clk),
        .rst_b(rst_b),
        .in_valid(adc_valid & adc_ready),
        .in_ready(buf_in_ready),
        .in_data(take_pix),
        .out_valid(buf_valid),
        .out_ready(out_load),
        .out_data(buf_pix)
    );

    // ---- output stage: data, line sync, field, strobe, slicer
    pof_pkg::pof_rgb_s rgb_q;
    pof_pkg::pof_rgb_s rgb_d;
    logic hs_prev_q;
    logic hs_prev_d;
    logic [pof_pkg::DUR_W-1:0] line_cnt_q;
    logic [pof_pkg::DUR_W-1:0] line_cnt_d;
    logic [pof_pkg::LINE_W-1:0] pos_q;
    logic [pof_pkg::LINE_W-1:0] pos_d;
    logic [pof_pkg::LINE_W-1:0] len_q;
    logic [pof_pkg::LINE_W-1:0] len_d;
    logic field_q;
    logic field_d;
    logic stb_q;
    logic stb_d;
    logic slice_q;
    logic slice_d;
    logic line_act;
    logic hs_edge;

    assign line_act = (line_cnt_q != 8'h00);
    assign hs_edge = out_load & buf_pix.hsync & ~hs_prev_q;

    always_comb
    begin
        rgb_d = rgb_q;
        hs_prev_d = hs_prev_q;
        line_cnt_d = line_cnt_q;
        pos_d = pos_q;
        len_d = len_q;
        field_d = field_q;
        if (out_load)
        begin
            // words pass with bit 9 as MSB
            rgb_d = buf_pix.rgb;
            hs_prev_d = buf_pix.hsync;
            pos_d = pos_q + 12'h001;
            if (line_act)
            begin
                line_cnt_d = line_cnt_q - 8'h01;
            end
            // regenerated pulse starts on leading edge
            if (hs_edge)
            begin
                line_cnt_d = cfg_l_q.line_dur;
                len_d = pos_q;
                pos_d = 12'h000;
            end
        end
        // vsync late in the line marks the odd field
        if (vs_rise)
        begin
            field_d = (pos_q >= {1'b0, len_q[pof_pkg::LINE_W-1:1]});
        end
        // strobe source chosen by the select field
        unique case (cfg_l_q.strobe_sel)
            // pixel, quarter-shifted and double from one counter
            pof_pkg::POF_STB_PIXEL: stb_d = ~rel[1];
            pof_pkg::POF_STB_QUARTER: stb_d = ~relq[1];
            pof_pkg::POF_STB_DOUBLE: stb_d = ~rel[0];
            // half-rate strobe from the upper counter bit
            pof_pkg::POF_STB_HALF: stb_d = ~rel[2];
        endcase
        // codes follow the listed source order
        unique case (cfg_l_q.slice_sel)
            // raw sources pass without further processing
            pof_pkg::POF_SLICE_GREEN_RAW: slice_d = green_s;
            pof_pkg::POF_SLICE_HSYNC_RAW: slice_d = hs_s;
            pof_pkg::POF_SLICE_REGEN: slice_d = line_act;
            pof_pkg::POF_SLICE_FILT: slice_d = filt_q;
        endcase
    end

    always_ff @(posedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rgb_q <= '0;
            hs_prev_q <= 1'b0;
            line_cnt_q <= 8'h00;
            pos_q <= 12'h000;
            len_q <= 12'h000;
            field_q <= 1'b0;
            stb_q <= 1'b0;
            slice_q <= 1'b0;
        end
        else
        begin
            rgb_q <= rgb_d;
            hs_prev_q <= hs_prev_d;
            line_cnt_q <= line_cnt_d;
            pos_q <= pos_d;
            len_q <= len_d;
            field_q <= field_d;
            stb_q <= stb_d;
            slice_q <= slice_d;
        end
    end

    assign red_out = rgb_q.red;
    assign green_out = rgb_q.green;
    assign blue_out = rgb_q.blue;
    assign output_strobe_clock = stb_q;
    // programmable polarity on the regenerated pulse
    assign line_sync_out = line_act ^ cfg_l_q.line_pol;
    assign field_parity_out = field_q;
    // slicer pin driven from the registered mux
    assign sync_slicer_out = slice_q;

    // ---- checks
    slicer_hsync_a: assert property (
        @(posedge link_clk) disable iff (!rst_b || cfg_upd)
        cfg_l_q.slice_sel == pof_pkg::POF_SLICE_HSYNC_RAW |=> sync_slicer_out == $past(hs_s))
        else $error("slicer does not follow raw hsync");
    slicer_green_a: assert property (
        @(posedge link_clk) disable iff (!rst_b || cfg_upd)
        cfg_l_q.slice_sel == pof_pkg::POF_SLICE_GREEN_RAW
        |=> sync_slicer_out == $past(green_s))
        else $error("slicer alters raw green sync");
    field_update_a: assert property (
        @(posedge link_clk) disable iff (!rst_b)
        $changed(field_parity_out) |-> $past(vs_rise))
        else $error("field parity changed without vsync edge");
    msb_lane_a: assert property (
        @(posedge link_clk) disable iff (!rst_b)
        out_load |=> red_out[pof_pkg::COLOR_MSB] == $past(buf_pix.rgb.red[pof_pkg::COLOR_MSB]))
        else $error("red msb not on bit 9");
    load_slot_a: assert property (
        @(posedge link_clk) disable iff (!rst_b)
        out_load |-> (sc_q[1:0] - cfg_l_q.phase) == pof_pkg::DATA_SLOT)
        else $error("output loaded off its slot");
    sample_phase_a: assert property (
        @(posedge link_clk) disable iff (!rst_b)
        adc_valid && adc_ready |-> sc_q[1:0] == cfg_l_q.phase)
        else $error("sample taken off the phase slot");
    line_moves_a: assert property (
        @(posedge link_clk) disable iff (!rst_b || steady_q != pof_pkg::STEADY_MAX)
        $changed(line_sync_out) |-> $past(out_load))
        else $error("line sync moved apart from data");
    double_strobe_a: assert property (
        @(posedge link_clk) disable iff (!rst_b || cfg_upd || resync)
        steady_q == pof_pkg::STEADY_MAX && cfg_l_q.strobe_sel == pof_pkg::POF_STB_DOUBLE
        |=> output_strobe_clock != $past(output_strobe_clock))
        else $error("double strobe not toggling");
    half_strobe_a: assert property (
        @(posedge link_clk) disable iff (!rst_b || cfg_upd || resync)
        steady_q == pof_pkg::STEADY_MAX && cfg_l_q.strobe_sel == pof_pkg::POF_STB_HALF
        && $rose(output_strobe_clock) |-> output_strobe_clock [*4] ##1 !output_strobe_clock)
        else $error("half strobe high time wrong");
    ext_align_a: assert property (
        @(posedge link_clk) disable iff (!rst_b)
        resync |=> sc_q[1:0] == 2'h0)
        else $error("external edge did not realign");
    line_start_a: assert property (
        @(posedge link_clk) disable iff (!rst_b)
        hs_edge && cfg_l_q.line_dur != 8'h00 && !cfg_upd |=> line_act)
        else $error("line sync pulse did not start");
endmodule
`default_nettype wire

/* File: tb/pof_sink_model.sv */
/*
 * pof_sink_model: downstream display logic that captures pixels on the strobe clock.
 * Assumes: strobe and colour buses come straight from pof_top.
 */
`default_nettype none
module pof_sink_model (
    input wire logic output_strobe_clock,
    input wire pof_pkg::pof_rgb_s rgb,
    input wire logic stall,
    output logic out_ready,
    output pof_pkg::pof_rgb_s cap
);
    timeunit 1ns;
    timeprecision 1ps;
    // back-pressure follows the bench's stall request
    assign out_ready = !stall;
    always_ff @(posedge output_strobe_clock)
    begin
        cap <= rgb;
    end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
/*
 * testbench: directed scenarios for pof_top with a downstream sink model.
 * Assumes: pof_pkg and pof_sink_model are compiled first.
 */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_b = 1'b0;
    pof_pkg::pof_cfg_s cfg = pof_pkg::CFG_RST;
    logic cfg_valid = 1'b0;
    logic green_in = 1'b0;
    logic hsync_in = 1'b0;
    logic vsync_in = 1'b0;
    logic ext_in = 1'b0;
    logic adc_valid = 1'b0;
    logic stall = 1'b0;
    pof_pkg::pof_rgb_s adc_pix = '0;
    logic cfg_busy, adc_ready, out_ready, strobe, line_sync, slicer, field_o;
    logic [pof_pkg::COLOR_W-1:0] red_o, green_o, blue_o;
    pof_pkg::pof_rgb_s rgb_seen, cap;
    int bad_count = 0;
    int comparisons = 0;

    assign rgb_seen = {red_o, green_o, blue_o};

    initial forever #2 clk = ~clk;
    initial
    begin
        #7;
        forever #24 link_clk = ~link_clk;
    end

    pof_top dut (
        .clk(clk), .rst_b(rst_b), .cfg(cfg), .cfg_valid(cfg_valid), .cfg_busy(cfg_busy),
        .link_clk(link_clk), .external_pixel_clock_in(ext_in),
        .green_sync_input(green_in), .horizontal_sync_input(hsync_in),
        .vertical_sync_input(vsync_in), .adc_valid(adc_valid), .adc_ready(adc_ready),
        .adc_pix(adc_pix), .out_ready(out_ready), .red_out(red_o), .green_out(green_o),
        .blue_out(blue_o), .output_strobe_clock(strobe), .line_sync_out(line_sync),
        .field_parity_out(field_o), .sync_slicer_out(slicer)
    );

    pof_sink_model sink (
        .output_strobe_clock(strobe), .rgb(rgb_seen), .stall(stall),
        .out_ready(out_ready), .cap(cap)
    );

    task automatic report_and_stop;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic set_cfg(input pof_pkg::pof_cfg_s c);
        int n;
        @(negedge clk);
        cfg = c;
        cfg_valid = 1'b1;
        @(negedge clk);
        cfg_valid = 1'b0;
        for (n = 0; n < 100 && cfg_busy !== 1'b0; n++) @(negedge clk);
        if (n == 100)
        begin
            check("cfg_busy", 0, 1);
            report_and_stop();
        end
        repeat (6) @(negedge link_clk);
    endtask

    // offer one word, hold it until taken or the bound runs out
    task automatic send(input pof_pkg::pof_rgb_s w, input int bound, output logic took);
        int n;
        @(negedge link_clk);
        adc_valid = 1'b1;
        adc_pix = w;
        for (n = 0; n < bound && adc_ready !== 1'b1; n++) @(negedge link_clk);
        took = (n < bound);
        if (took) @(posedge link_clk);
        @(negedge link_clk);
        adc_valid = 1'b0;
    endtask

    task automatic t_slicer;
        pof_pkg::pof_cfg_s c;
        int s;
        int v;
        c = pof_pkg::CFG_RST;
        for (s = 0; s < 4; s++)
        begin
            c.slice_sel = pof_pkg::pof_slice_e'(s[1:0]);
            set_cfg(c);
            for (v = 0; v < 2; v++)
            begin
                green_in = (s == 0) ? v[0] : !v[0];
                hsync_in = (s == 0) ? !v[0] : v[0];
                repeat (12) @(negedge link_clk);
                check("slicer", (s == 2) ? 0 : v, slicer);
            end
        end
        green_in = 1'b0;
        hsync_in = 1'b0;
    endtask

    task automatic t_latency;
        pof_pkg::pof_cfg_s c;
        pof_pkg::pof_rgb_s w;
        pof_pkg::pof_rgb_s prev;
        logic took;
        int p;
        c = pof_pkg::CFG_RST;
        for (p = 0; p < 2; p++)
        begin
            c.phase = p[1:0];
            set_cfg(c);
            w.red = 10'h200 + 10'(p);
            w.green = 10'h155;
            w.blue = 10'h0aa + 10'(p);
            prev = rgb_seen;
            send(w, 32, took);
            check("took", 1, took);
            check("strobe at take", 1, strobe);
            @(negedge link_clk);
            check("held", prev, rgb_seen);
            @(posedge link_clk);
            @(negedge link_clk);
            check("rgb", w, rgb_seen);
            check("strobe at load", 0, strobe);
            check("msb", 1, red_o[pof_pkg::COLOR_MSB]);
            repeat (4) @(posedge link_clk);
            @(negedge link_clk);
            check("captured", w, cap);
        end
    endtask

    task automatic t_stall;
        pof_pkg::pof_rgb_s w[3];
        logic took;
        int i;
        int n;
        w[0] = {10'h011, 10'h022, 10'h033};
        w[1] = {10'h3c4, 10'h255, 10'h166};
        w[2] = {10'h077, 10'h088, 10'h099};
        stall = 1'b1;
        for (i = 0; i < 3; i++)
        begin
            send(w[i], 16, took);
            check("accepted", (i < 2) ? 1 : 0, took);
        end
        stall = 1'b0;
        for (i = 0; i < 2; i++)
        begin
            for (n = 0; n < 40 && rgb_seen !== w[i]; n++) @(negedge link_clk);
            check("drain", w[i], rgb_seen);
            if (n == 40) report_and_stop();
        end
    endtask

    task automatic t_strobe;
        pof_pkg::pof_cfg_s c;
        int exp_rises[4] = '{4, 4, 8, 2};
        int s;
        int rises;
        logic last;
        int n;
        c = pof_pkg::CFG_RST;
        for (s = 0; s < 4; s++)
        begin
            c.strobe_sel = pof_pkg::pof_stb_e'(s[1:0]);
            set_cfg(c);
            for (n = 0; n < 8 && adc_ready !== 1'b1; n++) @(negedge link_clk);
            @(negedge link_clk);
            // strobe level one cycle after the sample slot
            if (s < 3) check("strobe phase", (s == 1) ? 0 : 1, strobe);
            rises = 0;
            last = strobe;
            repeat (16)
            begin
                @(negedge link_clk);
                if (strobe === 1'b1 && last === 1'b0) rises++;
                last = strobe;
            end
            check("strobe rises", exp_rises[s], rises);
        end
    endtask

    task automatic t_line;
        pof_pkg::pof_cfg_s c;
        logic took;
        int pol;
        c = pof_pkg::CFG_RST;
        c.line_dur = 8'h01;
        for (pol = 0; pol < 2; pol++)
        begin
            c.line_pol = pol[0];
            set_cfg(c);
            send({10'h101, 10'h102, 10'h103}, 32, took);
            check("took", 1, took);
            repeat (8) @(negedge link_clk);
            check("line idle", pol, line_sync);
            hsync_in = 1'b1;
            repeat (8) @(negedge link_clk);
            send({10'h2f1, 10'h2f2, 10'h2f3}, 32, took);
            check("took", 1, took);
            repeat (3) @(posedge link_clk);
            @(negedge link_clk);
            check("line active", !pol[0], line_sync);
            hsync_in = 1'b0;
            repeat (8) @(negedge link_clk);
        end
    endtask

    task automatic pulse_vsync(input logic exp);
        vsync_in = 1'b1;
        repeat (6) @(negedge link_clk);
        check("field", exp, field_o);
        vsync_in = 1'b0;
        repeat (4) @(negedge link_clk);
    endtask

    // hsync per word 0,1,0,0,1,0,0,1: line length 3 words
    task automatic t_field;
        logic [7:0] hs_seq;
        logic took;
        int i;
        hs_seq = 8'h92;
        for (i = 0; i < 8; i++)
        begin
            if (i == 7) pulse_vsync(1'b1);
            hsync_in = hs_seq[i];
            repeat (4) @(negedge link_clk);
            send({10'h0f0, 10'h0f1, 10'(i)}, 32, took);
            check("took", 1, took);
            repeat (4) @(negedge link_clk);
        end
        pulse_vsync(1'b0);
        hsync_in = 1'b0;
    endtask

    // two external edges six link cycles apart must each realign the slot
    task automatic t_ext;
        pof_pkg::pof_cfg_s c;
        int k;
        c = pof_pkg::CFG_RST;
        c.clk_src_ext = 1'b1;
        set_cfg(c);
        for (k = 0; k < 2; k++)
        begin
            @(negedge link_clk);
            ext_in = 1'b1;
            repeat (3) @(negedge link_clk);
            check("ext slot", 1, adc_ready);
            ext_in = 1'b0;
            repeat (2 + k) @(negedge link_clk);
        end
        set_cfg(pof_pkg::CFG_RST);
    endtask

    initial
    begin
        repeat (20) @(negedge clk);
        repeat (2) @(negedge link_clk);
        check("reset rgb", 0, rgb_seen);
        check("reset line", 0, line_sync);
        check("reset busy", 0, cfg_busy);
        check("reset field", 0, field_o);
        @(negedge clk);
        rst_b = 1'b1;
        t_slicer();
        t_latency();
        t_stall();
        t_strobe();
        t_line();
        t_field();
        t_ext();
        report_and_stop();
    end
endmodule
`default_nettype wire
